// >>> hw/blsr_lock.sv
// module: per-block lock bits, lock instructions and software reset sequence
//
// How it works
// - lock bits protect only when scheme select set
// - scheme clear: legacy protect result decides instead
// - lock bits volatile, all ones after reset
// - opcode 39h plus address clears one lock
// - single unlock needs write enable latch set
// - opcode and address bits taken on rising clock
// - opcode 3Dh plus address shifts lock byte out
// - returned byte lsb one means block locked
// - opcode 7Eh alone sets every lock bit
// - opcode 98h alone clears all, needs latch
// - global lock refused without write enable latch
// - software reset aborts work, drops volatile state
// - reset only after 66h then 99h
// - other command after 66h disarms the reset
// - reset lasts 30us, commands ignored meanwhile
// - opcode 36h plus address sets one lock
`timescale 1ns/1ps
module blsr_lock (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        spi_sck,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    output logic             spi_miso_oe,
    input  wire logic        write_enable_latch,
    input  wire logic        protect_scheme_select,
    input  wire logic        legacy_protect_hit,
    input  wire logic        prog_erase_req,
    input  wire logic [23:0] prog_erase_addr,
    output logic             prog_erase_grant,
    output logic             prog_erase_deny,
    output logic             volatile_reset
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    localparam int IW = blsr_pkg::LOCK_IDX_W; // lock index width

    blsr_pkg::blsr_rx_type              rx;                 // receiver events
    blsr_pkg::blsr_state_type           st_q,    st_d;      // decoder state
    logic [2:0]                         cnt_q,   cnt_d;     // bytes in this frame
    logic [7:0]                         op_q,    op_d;      // latched opcode
    logic [IW-1:0]                      idx_q,   idx_d;     // addressed lock
    logic [blsr_pkg::NUM_LOCKS-1:0]     lock_q,  lock_d;    // lock bits
    logic                               arm_q,   arm_d;     // reset armed
    logic [11:0]                        rcnt_q,  rcnt_d;    // reset interval
    logic [7:0]                         osh_q,   osh_d;     // read-out byte
    logic                               miso_q,  miso_d;    // serial out
    logic                               oe_q,    oe_d;      // serial out enable
    logic                               vrst_q,  vrst_d;    // volatile reset level
    logic                               gnt_q,   gnt_d;     // request granted
    logic                               deny_q,  deny_d;    // request refused
    logic                               exec;               // complete command
    logic                               hit;                // request is protected
    logic [IW-1:0]                      req_idx;            // lock of the request

    // ------------------------------------------------------------------
    // serial receiver
    // ------------------------------------------------------------------
    blsr_spi_rx u_rx (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .spi_sck  (spi_sck),
        .spi_cs_n (spi_cs_n),
        .spi_mosi (spi_mosi),
        .rx       (rx)
    );

    // ------------------------------------------------------------------
    // next state for the decoder, lock bits and protection check
    // ------------------------------------------------------------------
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        op_d    = op_q;
        idx_d   = idx_q;
        lock_d  = lock_q;
        arm_d   = arm_q;
        rcnt_d  = rcnt_q;
        osh_d   = osh_q;
        miso_d  = miso_q;
        oe_d    = oe_q;
        vrst_d  = 1'b0;
        gnt_d   = 1'b0;
        deny_d  = 1'b0;
        // a command counts once select rises after at least one byte
        exec    = rx.frame_end && (st_q == blsr_pkg::BLSR_ST_CMD) && (cnt_q != 3'h0);
        req_idx = prog_erase_addr[blsr_pkg::ADDR_W-1 -: IW];
        case (st_q)
            blsr_pkg::BLSR_ST_CMD: begin
                if (rx.frame_start) begin
                    cnt_d = 3'h0;
                end
                if (rx.byte_valid) begin
                    // saturate so an overlong frame never matches a length
                    cnt_d = (cnt_q == blsr_pkg::CNT_MAX) ? blsr_pkg::CNT_MAX
                                                         : cnt_q + 3'h1;
                    if (cnt_q == 3'h0) begin
                        op_d = rx.data;
                    end
                    if (cnt_q == blsr_pkg::CNT_ADDR_HI) begin
                        idx_d = rx.data[7 -: IW];
                    end
                    if (cnt_q == blsr_pkg::CNT_ADDR_LO && op_q == blsr_pkg::OP_READ_LOCK) begin
                        // status byte: lsb is the lock bit, rest zero
                        osh_d = {7'h00, lock_q[idx_q]};
                        st_d  = blsr_pkg::BLSR_ST_READ;
                        arm_d = 1'b0;
                    end
                end
                if (exec) begin
                    cnt_d = 3'h0;
                    // only a lone 66h leaves the reset armed
                    arm_d = (op_q == blsr_pkg::OP_RST_ENABLE) && (cnt_q == blsr_pkg::CNT_OPCODE);
                    case (op_q)
                        blsr_pkg::OP_LOCK_ONE: begin
                            if (cnt_q == blsr_pkg::CNT_FULL && write_enable_latch) begin
                                lock_d[idx_q] = 1'b1;
                            end
                        end
                        blsr_pkg::OP_UNLOCK_ONE: begin
                            if (cnt_q == blsr_pkg::CNT_FULL && write_enable_latch) begin
                                lock_d[idx_q] = 1'b0;
                            end
                        end
                        blsr_pkg::OP_LOCK_ALL: begin
                            if (cnt_q == blsr_pkg::CNT_OPCODE && write_enable_latch) begin
                                lock_d = '1;
                            end
                        end
                        blsr_pkg::OP_UNLOCK_ALL: begin
                            if (cnt_q == blsr_pkg::CNT_OPCODE && write_enable_latch) begin
                                lock_d = '0;
                            end
                        end
                        blsr_pkg::OP_RST_DEVICE: begin
                            if (cnt_q == blsr_pkg::CNT_OPCODE && arm_q) begin
                                st_d   = blsr_pkg::BLSR_ST_RESET;
                                rcnt_d = 12'h000;
                            end
                        end
                        default: begin
                            // other opcodes belong to other blocks
                        end
                    endcase
                end
            end
            blsr_pkg::BLSR_ST_READ: begin
                // repeat the status byte for as long as the host clocks
                if (rx.fall_edge) begin
                    miso_d = osh_q[7];
                    oe_d   = 1'b1;
                    osh_d  = {osh_q[6:0], osh_q[7]};
                end
                if (!rx.active) begin
                    st_d  = blsr_pkg::BLSR_ST_CMD;
                    oe_d  = 1'b0;
                    cnt_d = 3'h0;
                end
            end
            blsr_pkg::BLSR_ST_SKIP: begin
                // a frame already open when reset ends is dropped whole
                if (!rx.active) begin
                    st_d  = blsr_pkg::BLSR_ST_CMD;
                    cnt_d = 3'h0;
                end
            end
            blsr_pkg::BLSR_ST_RESET: begin
                // frames are ignored; volatile state held at power-on values
                vrst_d = 1'b1;
                lock_d = '1;
                arm_d  = 1'b0;
                oe_d   = 1'b0;
                rcnt_d = rcnt_q + 12'h001;
                if (rcnt_q == blsr_pkg::RST_LAST) begin
                    st_d  = rx.active ? blsr_pkg::BLSR_ST_SKIP : blsr_pkg::BLSR_ST_CMD;
                    cnt_d = 3'h0;
                end
            end
            default: begin
                st_d = blsr_pkg::BLSR_ST_CMD;
            end
        endcase
        // protection check; nothing is granted during a reset
        hit = protect_scheme_select ? lock_q[req_idx]
                                    : legacy_protect_hit;
        if (prog_erase_req) begin
            if (hit || st_q == blsr_pkg::BLSR_ST_RESET) begin
                deny_d = 1'b1;
            end else begin
                gnt_d = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q   <= blsr_pkg::BLSR_ST_CMD;
            cnt_q  <= 3'h0;
            op_q   <= 8'h00;
            idx_q  <= '0;
            lock_q <= {blsr_pkg::NUM_LOCKS{blsr_pkg::LOCK_RST_VAL}};
            arm_q  <= 1'b0;
            rcnt_q <= 12'h000;
            osh_q  <= 8'h00;
            miso_q <= 1'b0;
            oe_q   <= 1'b0;
            vrst_q <= 1'b0;
            gnt_q  <= 1'b0;
            deny_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            op_q   <= op_d;
            idx_q  <= idx_d;
            lock_q <= lock_d;
            arm_q  <= arm_d;
            rcnt_q <= rcnt_d;
            osh_q  <= osh_d;
            miso_q <= miso_d;
            oe_q   <= oe_d;
            vrst_q <= vrst_d;
            gnt_q  <= gnt_d;
            deny_q <= deny_d;
        end
    end

    assign spi_miso         = miso_q;
    assign spi_miso_oe      = oe_q;
    assign volatile_reset   = vrst_q;
    assign prog_erase_grant = gnt_q;
    assign prog_erase_deny  = deny_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_cmd_end(logic [7:0] op, logic [2:0] n);
        exec && op_q == op && cnt_q == n;
    endsequence

    sequence s_reset_fire;
        s_cmd_end(blsr_pkg::OP_RST_DEVICE, blsr_pkg::CNT_OPCODE) ##0 arm_q;
    endsequence

    property p_lock_scheme;
        prog_erase_req && protect_scheme_select && lock_q[req_idx] |=> prog_erase_deny;
    endproperty
    a_lock_scheme: assert property (p_lock_scheme) else $error("locked block granted");

    property p_legacy_scheme;
        prog_erase_req && !protect_scheme_select && !legacy_protect_hit
            && st_q != blsr_pkg::BLSR_ST_RESET |=> prog_erase_grant && !prog_erase_deny;
    endproperty
    a_legacy_scheme: assert property (p_legacy_scheme) else $error("legacy grant lost");

    property p_reset_locks;
        st_q == blsr_pkg::BLSR_ST_RESET |=> &lock_q;
    endproperty
    a_reset_locks: assert property (p_reset_locks) else $error("locks not set by reset");

    property p_unlock_one;
        s_cmd_end(blsr_pkg::OP_UNLOCK_ONE, blsr_pkg::CNT_FULL) ##0 write_enable_latch
            |=> !lock_q[$past(idx_q)];
    endproperty
    a_unlock_one: assert property (p_unlock_one) else $error("unlock one failed");

    property p_unlock_refused;
        s_cmd_end(blsr_pkg::OP_UNLOCK_ONE, blsr_pkg::CNT_FULL) ##0 !write_enable_latch
            |=> lock_q == $past(lock_q);
    endproperty
    a_unlock_refused: assert property (p_unlock_refused) else $error("unlock without latch");

    property p_read_byte;
        st_q == blsr_pkg::BLSR_ST_CMD && rx.byte_valid && cnt_q == blsr_pkg::CNT_ADDR_LO
            && op_q == blsr_pkg::OP_READ_LOCK
            |=> st_q == blsr_pkg::BLSR_ST_READ && osh_q == {7'h00, $past(lock_q[idx_q])};
    endproperty
    a_read_byte: assert property (p_read_byte) else $error("lock status byte wrong");

    property p_lock_all;
        s_cmd_end(blsr_pkg::OP_LOCK_ALL, blsr_pkg::CNT_OPCODE) ##0 write_enable_latch |=> &lock_q;
    endproperty
    a_lock_all: assert property (p_lock_all) else $error("global lock failed");

    property p_lock_all_refused;
        s_cmd_end(blsr_pkg::OP_LOCK_ALL, blsr_pkg::CNT_OPCODE) ##0 !write_enable_latch
            |=> lock_q == $past(lock_q);
    endproperty
    a_lock_all_refused: assert property (p_lock_all_refused) else $error("lock without latch");

    property p_unlock_all;
        s_cmd_end(blsr_pkg::OP_UNLOCK_ALL, blsr_pkg::CNT_OPCODE) ##0 write_enable_latch
            |=> lock_q == '0;
    endproperty
    a_unlock_all: assert property (p_unlock_all) else $error("global unlock failed");

    property p_reset_start;
        s_reset_fire |=> st_q == blsr_pkg::BLSR_ST_RESET ##1 volatile_reset [*8];
    endproperty
    a_reset_start: assert property (p_reset_start) else $error("reset not entered");

    property p_disarm;
        exec && !(op_q == blsr_pkg::OP_RST_ENABLE && cnt_q == blsr_pkg::CNT_OPCODE) |=> !arm_q;
    endproperty
    a_disarm: assert property (p_disarm) else $error("reset stays armed");

    property p_reset_len;
        st_q == blsr_pkg::BLSR_ST_RESET && $past(st_q) == blsr_pkg::BLSR_ST_RESET
            && st_d != blsr_pkg::BLSR_ST_RESET |-> rcnt_q == blsr_pkg::RST_LAST;
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset interval wrong");

endmodule // blsr_lock

// >>> hw/blsr_pkg.sv
// package: opcodes, lock map, timing and carrier types for the block lock logic
package blsr_pkg;

    // ------------------------------------------------------------------
    // instruction opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_LOCK_ONE   = 8'h36; // lock one block
    localparam logic [7:0] OP_UNLOCK_ONE = 8'h39; // unlock one block
    localparam logic [7:0] OP_READ_LOCK  = 8'h3d; // read one lock bit
    localparam logic [7:0] OP_LOCK_ALL   = 8'h7e; // lock every block
    localparam logic [7:0] OP_UNLOCK_ALL = 8'h98; // unlock every block
    localparam logic [7:0] OP_RST_ENABLE = 8'h66; // arm software reset
    localparam logic [7:0] OP_RST_DEVICE = 8'h99; // fire software reset

    // ------------------------------------------------------------------
    // frame shape and lock map
    // ------------------------------------------------------------------
    localparam int         ADDR_W       = 24;     // address bits after opcode
    localparam int         LOCK_IDX_W   = 4;      // top address bits pick the lock
    localparam int         NUM_LOCKS    = 16;     // one lock bit per block
    localparam logic [2:0] CNT_OPCODE   = 3'h1;   // bytes in an opcode-only frame
    localparam logic [2:0] CNT_ADDR_HI  = 3'h1;   // count when first address byte lands
    localparam logic [2:0] CNT_ADDR_LO  = 3'h3;   // count when last address byte lands
    localparam logic [2:0] CNT_FULL     = 3'h4;   // opcode plus three address bytes
    localparam logic [2:0] CNT_MAX      = 3'h5;   // saturates: frame too long
    localparam logic       LOCK_RST_VAL = 1'b1;   // every block starts locked

    // ------------------------------------------------------------------
    // software reset interval
    // ------------------------------------------------------------------
    localparam int          SYS_CLK_MHZ = 100;                      // sys_clk rate
    localparam int          RST_TIME_US = 30;                       // reset duration
    localparam int          RST_CYCLES  = RST_TIME_US * SYS_CLK_MHZ; // cycles held
    localparam logic [11:0] RST_LAST    = 12'(RST_CYCLES - 1);      // final count

    // ------------------------------------------------------------------
    // carrier from the serial receiver to the command logic
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       active;      // chip select asserted (synchronised)
        logic       frame_start; // one cycle at select assertion
        logic       frame_end;   // one cycle at select release
        logic       byte_valid;  // one cycle, data holds a whole byte
        logic [7:0] data;        // received byte, first bit in msb
        logic       fall_edge;   // falling clock edge inside a frame
    } blsr_rx_type;

    // command decoder states
    typedef enum logic [1:0] {
        BLSR_ST_CMD,
        BLSR_ST_READ,
        BLSR_ST_SKIP,
        BLSR_ST_RESET
    } blsr_state_type;

endpackage

// >>> hw/blsr_spi_rx.sv
// module: synchronises the serial pins and assembles bytes and edge events
`timescale 1ns/1ps
module blsr_spi_rx (
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 spi_sck,
    input  wire logic                 spi_cs_n,
    input  wire logic                 spi_mosi,
    output blsr_pkg::blsr_rx_type     rx
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [2:0]            sck_q,  sck_d;   // [0] sync, [1] sync, [2] edge history
    logic [2:0]            cs_q,   cs_d;    // same chain for chip select
    logic [1:0]            mosi_q, mosi_d;  // two stages, matches clock delay
    logic [2:0]            bits_q, bits_d;  // bit position inside the byte
    logic [6:0]            sh_q,   sh_d;    // partial byte
    blsr_pkg::blsr_rx_type rx_q,   rx_d;    // registered events
    logic                  rise;            // rising clock edge seen
    logic                  fall;            // falling clock edge seen

    // ------------------------------------------------------------------
    // next state: edges only from second stage onward, first stage untouched
    // ------------------------------------------------------------------
    always_comb begin
        sck_d  = {sck_q[1:0], spi_sck};
        cs_d   = {cs_q[1:0], spi_cs_n};
        mosi_d = {mosi_q[0], spi_mosi};
        rise   = sck_q[1] & ~sck_q[2];
        fall   = ~sck_q[1] & sck_q[2];
        bits_d = bits_q;
        sh_d   = sh_q;
        rx_d   = '0;
        rx_d.active      = ~cs_q[1];
        rx_d.frame_start = cs_q[2] & ~cs_q[1];
        rx_d.frame_end   = ~cs_q[2] & cs_q[1];
        rx_d.fall_edge   = ~cs_q[1] & fall;
        if (cs_q[1]) begin
            // deselected: next frame starts on a byte boundary
            bits_d = 3'h0;
        end else if (rise) begin
            // data bit taken on the rising clock edge
            sh_d   = {sh_q[5:0], mosi_q[1]};
            bits_d = bits_q + 3'h1;
            if (bits_q == 3'h7) begin
                rx_d.byte_valid = 1'b1;
                rx_d.data       = {sh_q, mosi_q[1]};
            end
        end
    end

    // ------------------------------------------------------------------
    // registers; pins idle as deselected with clock low
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sck_q  <= 3'h0;
            cs_q   <= 3'h7;
            mosi_q <= 2'h0;
            bits_q <= 3'h0;
            sh_q   <= 7'h0;
            rx_q   <= '0;
        end else begin
            sck_q  <= sck_d;
            cs_q   <= cs_d;
            mosi_q <= mosi_d;
            bits_q <= bits_d;
            sh_q   <= sh_d;
            rx_q   <= rx_d;
        end
    end

    assign rx = rx_q;

    // a whole byte is only reported while the frame is open
    property p_byte_in_frame;
        @(posedge sys_clk) disable iff (sys_rst)
        rx_q.byte_valid |-> rx_q.active && !rx_q.frame_end;
    endproperty
    a_byte_in_frame: assert property (p_byte_in_frame)
        else $error("byte reported outside a frame");

endmodule // blsr_spi_rx

// >>> test/blsr_host.sv
// partner model: spi host that frames lock and reset instructions
`timescale 1ns/1ps
module blsr_host (
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    // ----------
    // idle bus
    // ----------
    // select high and clock parked low between frames (mode 0)
    initial begin
        spi_sck  = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // one frame: n bits from the top of d, miso shifted into r at each rise
    task automatic frame(input int n, input logic [39:0] d, output logic [7:0] r);
        // pins change by non-blocking assignment so they never race sys_clk
        r        = 8'h00;
        spi_cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            spi_mosi <= d[39-i];
            #62.5 spi_sck <= 1'b1;
            r = {r[6:0], spi_miso};
            #62.5 spi_sck <= 1'b0;
        end
        #62.5 spi_cs_n <= 1'b1;
        // stale data bit flips so it can never pass for a driven one
        spi_mosi <= ~spi_mosi;
        #100; // gap of ten system clocks, above the five asked for
    endtask
endmodule // blsr_host

// >>> test/tb.sv
// testbench: lock instructions, permission checks and software reset
`timescale 1ns/1ps
module tb;
    // ----------
    // signals
    // ----------
    logic        sys_clk   = 1'b0;
    logic        sys_rst   = 1'b1;
    logic        we_latch  = 1'b0;   // write enable latch level
    logic        lock_sel  = 1'b1;   // lock bits decide
    logic        leg       = 1'b0;   // legacy scheme hit
    logic        req       = 1'b0;
    logic [23:0] req_addr  = 24'h000000;
    logic        spi_sck, spi_cs_n, spi_mosi, spi_miso, oe, grant, deny, vrst;
    logic [7:0]  r;
    int          n_fail    = 0;
    int          cmp_count = 0;
    // an undriven line shows the inverse of its last value to the host
    wire         miso_pin  = oe ? spi_miso : ~spi_miso;

    always #5 sys_clk = ~sys_clk;

    blsr_host u_blsr_host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(miso_pin));
    blsr_lock u_blsr_lock (.sys_clk(sys_clk), .sys_rst(sys_rst), .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(oe), .write_enable_latch(we_latch), .protect_scheme_select(lock_sel),
        .legacy_protect_hit(leg), .prog_erase_req(req), .prog_erase_addr(req_addr),
        .prog_erase_grant(grant), .prog_erase_deny(deny), .volatile_reset(vrst));

    // ----------
    // tasks
    // ----------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd1(input logic [7:0] op);
        u_blsr_host.frame(8, {op, 32'h0}, r);
    endtask
    task automatic cmda(input logic [7:0] op, input logic [3:0] b);
        u_blsr_host.frame(32, {op, b, 20'h5a5a5, 8'h00}, r);
    endtask
    // read back one lock: byte is seven zeros then the lock bit
    task automatic rd(input logic [3:0] b, input logic lk);
        u_blsr_host.frame(40, {blsr_pkg::OP_READ_LOCK, b, 20'h0a5a5, 8'h00}, r);
        check(r, {7'h00, lk});
        check(oe, 1'b0);
    endtask
    // one-cycle request; verdict lands the cycle after
    task automatic perm(input logic [3:0] b, input logic ok);
        @(posedge sys_clk);
        req      <= 1'b1;
        req_addr <= {b, 20'h12345};
        @(posedge sys_clk);
        req <= 1'b0;
        #1;
        check(grant, ok);
        check(deny, !ok);
    endtask
    task automatic set_in(input logic w, input logic s, input logic l);
        @(posedge sys_clk);
        we_latch <= w;
        lock_sel <= s;
        leg <= l;
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------
    // sequence
    // ----------
    initial begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd(4'h0, 1'b1);
        rd(4'hf, 1'b1);
        perm(4'h2, 1'b0);
        cmda(blsr_pkg::OP_UNLOCK_ONE, 4'h2);
        cmd1(blsr_pkg::OP_UNLOCK_ALL);
        rd(4'h2, 1'b1);
        set_in(1'b1, 1'b1, 1'b0);
        cmda(blsr_pkg::OP_UNLOCK_ONE, 4'h2);
        rd(4'h2, 1'b0);
        rd(4'h3, 1'b1);
        perm(4'h2, 1'b1);
        set_in(1'b1, 1'b0, 1'b1);
        perm(4'h2, 1'b0);
        set_in(1'b1, 1'b0, 1'b0);
        perm(4'h3, 1'b1);
        set_in(1'b1, 1'b1, 1'b0);
        cmda(blsr_pkg::OP_LOCK_ONE, 4'h2);
        rd(4'h2, 1'b1);
        cmd1(blsr_pkg::OP_UNLOCK_ALL);
        rd(4'hf, 1'b0);
        set_in(1'b0, 1'b1, 1'b0);
        cmd1(blsr_pkg::OP_LOCK_ALL);
        rd(4'h9, 1'b0);
        set_in(1'b1, 1'b1, 1'b0);
        cmd1(blsr_pkg::OP_LOCK_ALL);
        rd(4'h9, 1'b1);
        cmd1(blsr_pkg::OP_UNLOCK_ALL);
        // no program running, so the reset pair is safe to send
        cmd1(blsr_pkg::OP_RST_ENABLE);
        rd(4'h0, 1'b0);
        cmd1(blsr_pkg::OP_RST_DEVICE);
        check(vrst, 1'b0);
        cmd1(blsr_pkg::OP_RST_ENABLE);
        cmd1(blsr_pkg::OP_RST_DEVICE);
        check(vrst, 1'b1);
        cmd1(blsr_pkg::OP_UNLOCK_ALL);
        perm(4'h5, 1'b0);
        // still inside the interval, then clearly past its end
        repeat (2800) @(posedge sys_clk);
        check(vrst, 1'b1);
        repeat (204) @(posedge sys_clk);
        check(vrst, 1'b0);
        rd(4'h5, 1'b1);
        report_and_stop();
    end

    // watchdog: the sequence needs about 110 us
    initial begin
        #400000;
        n_fail++;
        report_and_stop();
    end
endmodule // tb
